/* File: hdl/clock_breakpoint_debug.sv */
// Clock breakpoint debug block: per-domain clock gating units, event
// counter and frequency monitor on the first probe channel.
// Assumes one 200 MHz mclk for control and one gated line per domain.
//
// Overview of operation
// - One gating unit per user clock domain
// - Single or all-domain mode in every unit
// - Armed unit halts on next probe rise
// - Halt waits programmed delay 0..255 cycles
// - Forced halt ignores the delay count
// - Armed unit refuses arm, play and step
// - Halt on command without a trigger
// - All-domain halt, play and step walk domains in order
// - Halting one domain leaves others running
// - Play releases the gate, state kept
// - Step passes exactly one clock cycle
// - Reset command disarms units any time
// - New single domain discards old settings
// - Event counter counts probe rising edges
// - Stop counter to get final count
// - Frequency monitor reports megahertz
// - Measurement ends after monitor time
// - Monitor reset clears frequency to zero when idle
// - Second probe channel drives nothing
// - Halt within one domain cycle
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "clock_breakpoint_params.svh"
module clock_breakpoint_debug (
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire logic [`ADDR_W-1:0]        addr,
    input  wire logic [31:0]               wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic      [31:0]               rdata,
    input  wire logic                      probe_a,
    input  wire logic                      probe_b,
    output logic      [`NUM_DOMAINS-1:0]   gate_en
);
    localparam int ND = `NUM_DOMAINS;

    clock_breakpoint_pkg::reg_req_t        req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Probe synchroniser; probe_b deliberately unused
    logic                                  pa_s1_q;
    logic                                  pa_s2_q;
    logic                                  pa_s3_q;
    logic                                  pa_rise;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pa_s1_q <= 1'b0;
            pa_s2_q <= 1'b0;
            pa_s3_q <= 1'b0;
        end
        else
        begin
            pa_s1_q <= probe_a;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
        end
    end
    assign pa_rise = pa_s2_q & ~pa_s3_q;

    // Command decode
    logic                                  cmd_wr;
    clock_breakpoint_pkg::op_t             cmd_op;
    logic                                  cmd_all;
    logic [1:0]                            cmd_dom;
    assign cmd_wr  = req.wr && (req.addr == `CMD_OFFSET);
    assign cmd_op  = clock_breakpoint_pkg::op_t'(req.wdata[`CMD_OP_LSB +: 3]);
    assign cmd_all = req.wdata[`CMD_ALL_BIT];
    assign cmd_dom = req.wdata[`CMD_DOM_LSB +: 2];

    logic                                  all_mode_q;
    logic [1:0]                            sel_dom_q;
    logic [7:0]                            delay_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            all_mode_q <= 1'b0;
            sel_dom_q  <= 2'h0;
            delay_q    <= 8'h00;
        end
        else
        begin
            if (cmd_wr && (cmd_op != clock_breakpoint_pkg::OP_NONE))
            begin
                all_mode_q <= cmd_all;
                sel_dom_q  <= cmd_dom;
            end
            if (req.wr && (req.addr == `DELAY_OFFSET))
                delay_q <= req.wdata[7:0];
        end
    end

    // Domain change in single mode discards old domain's settings
    logic                                  dom_change;
    assign dom_change = cmd_wr && !cmd_all && !all_mode_q && (cmd_dom != sel_dom_q)
                        && (cmd_op != clock_breakpoint_pkg::OP_NONE);

    // All-domain sequencer: one domain per cycle in index order
    logic                                  seq_busy_q;
    logic [1:0]                            seq_idx_q;
    clock_breakpoint_pkg::op_t             seq_op_q;
    logic                                  any_armed;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            seq_busy_q <= 1'b0;
            seq_idx_q  <= 2'h0;
            seq_op_q   <= clock_breakpoint_pkg::OP_NONE;
        end
        else if (seq_busy_q)
        begin
            seq_idx_q <= seq_idx_q + 2'h1;
            if (seq_idx_q == 2'(ND - 1))
                seq_busy_q <= 1'b0;
        end
        else if (cmd_wr && cmd_all && (cmd_op inside {clock_breakpoint_pkg::OP_HALT,
                 clock_breakpoint_pkg::OP_PLAY, clock_breakpoint_pkg::OP_STEP}))
        begin
            seq_busy_q <= 1'b1;
            seq_idx_q  <= 2'h0;
            seq_op_q   <= cmd_op;
        end
    end

    // Per-domain gating units
    clock_breakpoint_pkg::unit_state_t     st_q [ND];
    logic [7:0]                            cnt_q [ND];
    logic [ND-1:0]                         gate_q;
    logic [ND-1:0]                         armed_v;
    genvar g;
    generate
        for (g = 0; g < ND; g++)
        begin : g_unit
            logic                          tgt;
            logic                          hit;
            clock_breakpoint_pkg::op_t     op;
            assign tgt = cmd_wr && (cmd_all || (cmd_dom == 2'(g)));
            assign hit = seq_busy_q && (seq_idx_q == 2'(g));
            assign op  = hit ? seq_op_q : ((tgt && !cmd_all) ? cmd_op
                                           : clock_breakpoint_pkg::OP_NONE);
            assign armed_v[g] = (st_q[g] == clock_breakpoint_pkg::ST_ARMED) ||
                                (st_q[g] == clock_breakpoint_pkg::ST_DELAY);
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    st_q[g]   <= clock_breakpoint_pkg::ST_RUN;
                    cnt_q[g]  <= 8'h00;
                    gate_q[g] <= 1'b1;
                end
                else if ((tgt && cmd_op == clock_breakpoint_pkg::OP_RESET) ||
                         (dom_change && sel_dom_q == 2'(g)))
                begin
                    st_q[g]   <= clock_breakpoint_pkg::ST_RUN;
                    cnt_q[g]  <= 8'h00;
                    gate_q[g] <= 1'b1;
                end
                else if (tgt && cmd_op == clock_breakpoint_pkg::OP_ARM && !armed_v[g])
                begin
                    st_q[g]   <= clock_breakpoint_pkg::ST_ARMED;
                    cnt_q[g]  <= delay_q;
                    gate_q[g] <= 1'b1;
                end
                else if (op == clock_breakpoint_pkg::OP_HALT)
                begin
                    st_q[g]   <= clock_breakpoint_pkg::ST_HALTED;
                    gate_q[g] <= 1'b0;
                end
                else
                begin
                    case (st_q[g])
                        clock_breakpoint_pkg::ST_ARMED:
                        begin
                            if (pa_rise)
                            begin
                                if (cnt_q[g] == 8'h00)
                                begin
                                    st_q[g]   <= clock_breakpoint_pkg::ST_HALTED;
                                    gate_q[g] <= 1'b0;
                                end
                                else
                                    st_q[g] <= clock_breakpoint_pkg::ST_DELAY;
                            end
                        end
                        clock_breakpoint_pkg::ST_DELAY:
                        begin
                            cnt_q[g] <= cnt_q[g] - 8'h01;
                            if (cnt_q[g] == 8'h01)
                            begin
                                st_q[g]   <= clock_breakpoint_pkg::ST_HALTED;
                                gate_q[g] <= 1'b0;
                            end
                        end
                        clock_breakpoint_pkg::ST_HALTED:
                        begin
                            if (op == clock_breakpoint_pkg::OP_PLAY)
                            begin
                                st_q[g]   <= clock_breakpoint_pkg::ST_RUN;
                                gate_q[g] <= 1'b1;
                            end
                            else if (op == clock_breakpoint_pkg::OP_STEP)
                                gate_q[g] <= 1'b1;
                            else
                                gate_q[g] <= 1'b0;
                        end
                        clock_breakpoint_pkg::ST_RUN:
                            gate_q[g] <= 1'b1;
                        default:
                            st_q[g] <= clock_breakpoint_pkg::ST_RUN;
                    endcase
                end
            end
        end
    endgenerate
    assign any_armed = |armed_v;

    // Gate enable from flops; gating cell latches it on the low phase
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            gate_en <= {ND{1'b1}};
        else
            gate_en <= gate_q;
    end

    // Event counter
    logic                                  ev_run_q;
    logic [31:0]                           ev_cnt_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ev_run_q <= 1'b0;
            ev_cnt_q <= 32'h0000_0000;
        end
        else if (cmd_wr && cmd_op == clock_breakpoint_pkg::OP_EVENT)
        begin
            ev_run_q <= req.wdata[`CMD_ALL_BIT];
            if (req.wdata[`CMD_ALL_BIT])
                ev_cnt_q <= 32'h0000_0000;
        end
        else if (ev_run_q && pa_rise)
            ev_cnt_q <= ev_cnt_q + 32'h0000_0001;
    end

    // Frequency monitor: MHz = edges / (N units * unit length in us)
    logic                                  fm_run_q;
    logic [15:0]                           fm_time_q;
    logic [15:0]                           fm_ms_q;
    logic [31:0]                           fm_tick_q;
    logic [31:0]                           fm_edges_q;
    logic [31:0]                           fm_result_q;
    logic                                  fm_done_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fm_time_q <= 16'h0001;
        else if (req.wr && (req.addr == `MON_TIME_OFFSET) && !fm_run_q)
            fm_time_q <= (req.wdata[15:0] == 16'h0000) ? 16'h0001 : req.wdata[15:0];
    end
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fm_run_q    <= 1'b0;
            fm_ms_q     <= 16'h0000;
            fm_tick_q   <= 32'h0000_0000;
            fm_edges_q  <= 32'h0000_0000;
            fm_result_q <= 32'h0000_0000;
            fm_done_q   <= 1'b0;
        end
        else if (cmd_wr && cmd_op == clock_breakpoint_pkg::OP_FREQ && !fm_run_q)
        begin
            if (req.wdata[`CMD_ALL_BIT])
            begin
                fm_run_q   <= 1'b1;
                fm_done_q  <= 1'b0;
                fm_ms_q    <= 16'h0000;
                fm_tick_q  <= 32'h0000_0000;
                fm_edges_q <= 32'h0000_0000;
            end
            else
            begin
                fm_result_q <= 32'h0000_0000;
                fm_done_q   <= 1'b0;
            end
        end
        else if (fm_run_q)
        begin
            if (pa_rise)
                fm_edges_q <= fm_edges_q + 32'h0000_0001;
            if (fm_tick_q == 32'(`MON_UNIT_CYCLES - 1))
            begin
                fm_tick_q <= 32'h0000_0000;
                fm_ms_q   <= fm_ms_q + 16'h0001;
                if (fm_ms_q + 16'h0001 == fm_time_q)
                begin
                    fm_run_q    <= 1'b0;
                    fm_done_q   <= 1'b1;
                    // Integer MHz; divider sits off the critical path at 200 MHz
                    fm_result_q <= fm_edges_q /
                                   (32'(fm_time_q) * 32'(`MON_UNIT_US));
                end
            end
            else
                fm_tick_q <= fm_tick_q + 32'h0000_0001;
        end
    end

    // Read port, data one cycle after strobe
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 32'h0000_0000;
        else if (req.rd)
        begin
            case (req.addr)
                `DELAY_OFFSET:    rdata <= {24'h000000, delay_q};
                `MON_TIME_OFFSET: rdata <= {16'h0000, fm_time_q};
                `STATUS_OFFSET:   rdata <= {16'h0000, 2'h0, sel_dom_q, all_mode_q,
                                            seq_busy_q, any_armed, ev_run_q, fm_run_q,
                                            fm_done_q, 2'h0, gate_q};
                `EVENT_OFFSET:    rdata <= ev_cnt_q;
                `FREQ_OFFSET:     rdata <= fm_result_q;
                default:          rdata <= 32'h0000_0000;
            endcase
        end
        else
            rdata <= 32'h0000_0000;
    end
endmodule : clock_breakpoint_debug

/* File: hdl/clock_breakpoint_params.svh */
// Offsets, fields and timing counts for the clock breakpoint debug block.
// Included by the package and the design; definitions only.
`ifndef CLOCK_BREAKPOINT_PARAMS_SVH
`define CLOCK_BREAKPOINT_PARAMS_SVH
`define NUM_DOMAINS        4
`define ADDR_W             4
`define CMD_OFFSET         4'h0
`define DELAY_OFFSET       4'h1
`define MON_TIME_OFFSET    4'h2
`define STATUS_OFFSET      4'h3
`define EVENT_OFFSET       4'h4
`define FREQ_OFFSET        4'h5
`define CMD_OP_LSB         0
`define CMD_ALL_BIT        4
`define CMD_DOM_LSB        8
`define CLK_MHZ            200
`define MON_UNIT_US        100
`define MON_UNIT_CYCLES    (`MON_UNIT_US * `CLK_MHZ)
`endif

/* File: hdl/clock_breakpoint_pkg.sv */
// Types shared by the clock breakpoint debug block.
// Assumes the params header is on the include path.
`include "clock_breakpoint_params.svh"
package clock_breakpoint_pkg;
    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_ARM    = 3'h1,
        OP_HALT   = 3'h2,
        OP_PLAY   = 3'h3,
        OP_STEP   = 3'h4,
        OP_RESET  = 3'h5,
        OP_EVENT  = 3'h6,
        OP_FREQ   = 3'h7
    } op_t;
    typedef enum logic [1:0] {
        ST_RUN    = 2'h0,
        ST_ARMED  = 2'h1,
        ST_DELAY  = 2'h3,
        ST_HALTED = 2'h2
    } unit_state_t;
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [31:0]        wdata;
        logic               wr;
        logic               rd;
    } reg_req_t;
endpackage : clock_breakpoint_pkg

/* File: testbench/clock_breakpoint_asserts.sv */
// Checker for the clock breakpoint debug block.
// Sees only the top ports; bound to the design below its endmodule.
`timescale 1ns/1ps
`include "clock_breakpoint_params.svh"
module clock_breakpoint_asserts (
    input wire logic                    mclk,
    input wire logic                    rst_b,
    input wire logic [`ADDR_W-1:0]      addr,
    input wire logic [31:0]             wdata,
    input wire logic                    wr,
    input wire logic                    rd,
    input wire logic [31:0]             rdata,
    input wire logic                    probe_a,
    input wire logic                    probe_b,
    input wire logic [`NUM_DOMAINS-1:0] gate_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    logic       cmd_wr;
    logic [1:0] dom;
    // Single-domain command writes only
    assign cmd_wr = wr && (addr == `CMD_OFFSET) && !wdata[`CMD_ALL_BIT];
    assign dom    = wdata[`CMD_DOM_LSB +: 2];
    sequence all_halt_walk_s;
        gate_en == 4'hE ##1 gate_en == 4'hC ##1 gate_en == 4'h8 ##1 gate_en == 4'h0;
    endsequence
    reset_state_a: assert property ($rose(rst_b) |-> gate_en == 4'hF)
        else $error("gates not open after reset");
    read_idle_a: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    unmapped_a: assert property (rd && addr > 4'h5 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    halt_one_a: assert property (cmd_wr && wdata[2:0] == 3'h2 |-> ##2 !gate_en[$past(dom, 2)])
        else $error("single halt did not close gate");
    play_one_a: assert property (cmd_wr && wdata[2:0] == 3'h3 |-> ##2 gate_en[$past(dom, 2)])
        else $error("play did not open gate");
    step_one_a: assert property (cmd_wr && wdata[2:0] == 3'h4 && !gate_en[dom]
        |-> ##2 gate_en[$past(dom, 2)] ##1 !gate_en[$past(dom, 3)]) else $error("step not one cycle");
    others_kept_a: assert property (cmd_wr && (wdata[2:0] == 3'h2 || wdata[2:0] == 3'h3)
        |-> ##2 ((gate_en ^ $past(gate_en, 2)) & ~(4'h1 << $past(dom, 2))) == 4'h0)
        else $error("other domain gate moved");
    all_halt_a: assert property (wr && addr == `CMD_OFFSET && wdata[4] && wdata[2:0] == 3'h2
        && gate_en == 4'hF |-> ##3 all_halt_walk_s) else $error("all-domain halt out of order");
    gate_cause_a: assert property ($rose(gate_en[0]) |->
        ($past(wr, 2) && $past(addr, 2) == `CMD_OFFSET) ||
        ($past(wr, 3) && $past(addr, 3) == `CMD_OFFSET))
        else $error("gate opened without a command");
endmodule : clock_breakpoint_asserts

bind clock_breakpoint_debug clock_breakpoint_asserts chk_u (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .addr    (addr),
    .wdata   (wdata),
    .wr      (wr),
    .rd      (rd),
    .rdata   (rdata),
    .probe_a (probe_a),
    .probe_b (probe_b),
    .gate_en (gate_en)
);

/* File: testbench/clock_breakpoint_debug_tb.sv */
// Self-checking bench for the clock breakpoint debug block.
// Assumes the host model drives the register port; bench drives probes.
`timescale 1ns/1ps
`include "clock_breakpoint_params.svh"
module clock_breakpoint_debug_tb;
    logic                    mclk;
    logic                    rst_b;
    logic                    probe_a;
    logic                    probe_b;
    logic [`ADDR_W-1:0]      addr;
    logic [31:0]             wdata;
    logic [31:0]             rdata;
    logic                    wr;
    logic                    rd;
    logic                    rd_s;
    logic [`NUM_DOMAINS-1:0] gate_en;
    int                      error_cnt;
    int                      num_checks;
    int                      cyc;
    int                      n;
    int                      d;
    int                      k;
    integer                  seed;
    clock_breakpoint_debug dut_u (
        .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .probe_a(probe_a), .probe_b(probe_b), .gate_en(gate_en)
    );
    debug_host_model host_u (
        .mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic gate_chk(input int cyc_n, input logic [3:0] exp);
        repeat (cyc_n) @(posedge mclk);
        @(negedge mclk);
        check({28'h0, gate_en}, {28'h0, exp});
    endtask : gate_chk
    task automatic complete_run();
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial
    begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    // Read data stand one cycle only, so sample mid-cycle
    always @(posedge mclk) rd_s <= rd;
    always @(negedge mclk)
        if (rd_s === 1'h1)
            check(rdata, host_u.exp_q.pop_front());
    // Whole run is about 20500 cycles, mostly the monitor window
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    initial
    begin
        error_cnt  = 0;
        num_checks = 0;
        seed       = 32'hB0951DDA;
        rst_b      = 1'h0;
        probe_a    = 1'h0;
        probe_b    = 1'h0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'h1;
        gate_chk(1, 4'hF);
        host_u.get_reg(`STATUS_OFFSET, 32'h0000000F);
        host_u.get_reg(`EVENT_OFFSET, 32'h0);
        host_u.get_reg(4'hA, 32'h0);
        host_u.cmd(3'h2, 1'h0, 2'h1);
        gate_chk(2, 4'hD);
        host_u.cmd(3'h3, 1'h0, 2'h1);
        gate_chk(2, 4'hF);
        host_u.cmd(3'h2, 1'h0, 2'h1);
        host_u.cmd(3'h4, 1'h0, 2'h1);
        n = 0;
        repeat (6)
        begin
            @(negedge mclk);
            n = n + gate_en[1];
        end
        check(n, 1);
        host_u.cmd(3'h3, 1'h0, 2'h1);
        d = $random(seed) & 32'hFF;
        host_u.arm(2'h0, d[7:0]);
        host_u.get_reg(`STATUS_OFFSET, 32'h0000020F);
        host_u.arm(2'h0, ~d[7:0]);
        @(posedge mclk);
        probe_b <= 1'h1;
        gate_chk(10, 4'hF);
        @(posedge mclk);
        probe_b <= 1'h0;
        probe_a <= 1'h1;
        n = 0;
        while (gate_en[0] === 1'h1 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        check(n, 5 + d);
        host_u.get_reg(`STATUS_OFFSET, 32'h0000000E);
        probe_a <= 1'h0;
        host_u.cmd(3'h3, 1'h0, 2'h0);
        host_u.put_reg(`DELAY_OFFSET, 32'h000000C8);
        host_u.cmd(3'h2, 1'h0, 2'h2);
        gate_chk(2, 4'hB);
        host_u.cmd(3'h3, 1'h0, 2'h2);
        host_u.arm(2'h2, 8'h00);
        host_u.get_reg(`STATUS_OFFSET, 32'h0000220F);
        host_u.cmd(3'h5, 1'h0, 2'h2);
        host_u.get_reg(`STATUS_OFFSET, 32'h0000200F);
        @(posedge mclk);
        probe_a <= 1'h1;
        gate_chk(10, 4'hF);
        @(posedge mclk);
        probe_a <= 1'h0;
        host_u.cmd(3'h2, 1'h1, 2'h0);
        for (k = 0; k < 4; k++)
            gate_chk(k == 0 ? 2 : 1, 4'hE << k);
        host_u.cmd(3'h3, 1'h1, 2'h0);
        gate_chk(6, 4'hF);
        host_u.cmd(3'h6, 1'h1, 2'h0);
        n = 1 + ($random(seed) & 32'hF);
        for (k = 0; k < n; k++)
        begin
            @(posedge mclk);
            probe_a <= 1'h1;
            probe_b <= 1'($random(seed));
            repeat (2) @(posedge mclk);
            probe_a <= 1'h0;
            repeat (3) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        host_u.get_reg(`EVENT_OFFSET, n);
        host_u.stop_events();
        host_u.get_reg(`EVENT_OFFSET, n);
        host_u.put_reg(`MON_TIME_OFFSET, 32'h00000001);
        host_u.cmd(3'h7, 1'h1, 2'h0);
        host_u.get_reg(`FREQ_OFFSET, 32'h0);
        // Six-cycle period at 200 MHz, 33.3 MHz, reads back truncated to 33
        for (k = 0; k < 20100; k++)
        begin
            @(posedge mclk);
            probe_a <= ((k % 6) < 3);
        end
        host_u.get_reg(`STATUS_OFFSET, 32'h0000084F);
        host_u.get_reg(`FREQ_OFFSET, 32'h00000021);
        host_u.cmd(3'h7, 1'h0, 2'h0);
        host_u.get_reg(`FREQ_OFFSET, 32'h0);
        repeat (4) @(posedge mclk);
        complete_run();
    end
endmodule : clock_breakpoint_debug_tb

/* File: testbench/debug_host_model.sv */
// Debug host model: drives the register port as the cable tool does.
// Assumes mclk from the bench; expected read data are noted in exp_q.
`timescale 1ns/1ps
`include "clock_breakpoint_params.svh"
module debug_host_model (
    input wire logic           mclk,
    output logic [`ADDR_W-1:0] addr,
    output logic [31:0]        wdata,
    output logic               wr,
    output logic               rd
);
    logic [31:0] exp_q[$];
    initial
    begin
        addr  = 4'h0;
        wdata = 32'h0;
        wr    = 1'h0;
        rd    = 1'h0;
    end
    task automatic put_reg(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge mclk);
        wr    <= 1'h0;
        // Released lines show junk, not the old value
        addr  <= ~a;
        wdata <= ~d;
    endtask : put_reg
    task automatic get_reg(input logic [`ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'h1;
        exp_q.push_back(e);
        @(posedge mclk);
        rd   <= 1'h0;
        addr <= ~a;
    endtask : get_reg
    task automatic cmd(input logic [2:0] op, input logic all, input logic [1:0] dom);
        put_reg(`CMD_OFFSET, {22'h0, dom, 3'h0, all, 1'h0, op});
    endtask : cmd
    task automatic arm(input logic [1:0] dom, input logic [7:0] dly);
        put_reg(`DELAY_OFFSET, {24'h0, dly});
        cmd(3'h1, 1'h0, dom);
    endtask : arm
    // Final count only after stop; bench makes one interim read first
    task automatic stop_events();
        cmd(3'h6, 1'h0, 2'h0);
    endtask : stop_events
endmodule : debug_host_model
